// >>> bench/rcs_agent_model.sv
// central agent driving the reset straps
`timescale 1ns/10ps
`default_nettype none
module rcs_agent_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // levels wanted across release: fast, speed, data line 0
    input wire logic [3:0] want,
    // strap pins
    output logic addr_line_fifteen_n,
    output logic [1:0] bus_speed_strap,
    output logic intc_data_line0
);
    logic hold = 1'b1;
    logic tog = 1'b0;
    // bench bus clock stands for whichever of the three bus speeds is strapped
    always @(posedge clk) hold <= !rst_n;
    always @(posedge clk) tog <= !tog;
    // held through release, then moving like bus traffic
    assign {addr_line_fifteen_n, bus_speed_strap, intc_data_line0} =
        (hold || !rst_n) ? want : want ^ {4{tog}};
endmodule : rcs_agent_model
`default_nettype wire

// >>> bench/rcs_strap_sampler_chk.sv
// port checker of the strap sampler
`timescale 1ns/10ps
`default_nettype none
module rcs_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins
    input wire logic addr_line_fifteen_n,
    input wire logic intc_data_line0,
    input wire logic stop_clock_request_n,
    input wire logic priority_snoop_req,
    // results
    input wire logic stop_grant_active,
    input wire logic fast_wake_active,
    input wire logic priority_snoop_ack,
    input wire logic symmetric_snoop_ack,
    input wire logic interrupt_latched,
    input wire logic intc_enabled
);
    logic rel;
    logic fw;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // strap copy taken only on the first edge out of reset
    always_ff @(posedge clk) rel <= !rst_n;
    always_ff @(posedge clk) if (rst_n && rel) fw <= !addr_line_fifteen_n;
    chk_stop_grant: assert property (
        (!fw && !stop_clock_request_n) [*4] |-> stop_grant_active)
        else $error("stop grant missing");
    chk_fast_wake: assert property (
        (fw && !stop_clock_request_n) [*4] |-> fast_wake_active)
        else $error("fast wake missing");
    chk_prio_snoop: assert property (
        fast_wake_active && priority_snoop_req |=> priority_snoop_ack)
        else $error("priority snoop dropped");
    chk_sym_blocked: assert property (
        fast_wake_active |=> !symmetric_snoop_ack && !interrupt_latched)
        else $error("fast wake serviced snoop");
    chk_intc_off: assert property (
        rel && !intc_data_line0 |=> !intc_enabled)
        else $error("enable not cleared");
    chk_intc_on: assert property (
        rel && intc_data_line0 |=> intc_enabled)
        else $error("enable not set");
    chk_intc_stays_off: assert property (
        !intc_enabled |=> !intc_enabled && !interrupt_latched)
        else $error("controller woke up");
    chk_enable_hold: assert property (
        $rose(intc_enabled) |-> !$past(rst_n))
        else $error("enable rose without reset");
    cover property (fast_wake_active);
    cover property (stop_grant_active);
    cover property (!intc_enabled);
endmodule : rcs_chk
bind rcs_strap_sampler rcs_chk rcs_chk_inst (.clk, .rst_n,
    .addr_line_fifteen_n, .intc_data_line0, .stop_clock_request_n,
    .priority_snoop_req, .stop_grant_active, .fast_wake_active,
    .priority_snoop_ack, .symmetric_snoop_ack, .interrupt_latched,
    .intc_enabled);
`default_nettype wire

// >>> bench/rcs_strap_sampler_test.sv
// self-checking bench of the strap sampler
`timescale 1ns/10ps
`default_nettype none
`include "rcs_params.svh"
module rcs_strap_sampler_test;
    logic clk = 0, rst_n = 0, stp_n = 1, p_rq = 0, s_rq = 0, i_rq = 0;
    logic [3:0] want = 4'h0, aw = 4'h0, ar = 4'h0, cfg [4];
    logic [31:0] wd = 32'h0;
    logic [1:0] spc;
    logic aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
    wire logic a15, d0, sg, fw, pa, sa, il, ie, aw_a, w_a, b_v, ar_a, r_v;
    wire logic [1:0] sp, br, rr;
    wire logic [31:0] rd;
    logic [65:0] q [$];
    int n_fail = 0, n_tests = 0, cyc = 0;
    rcs_agent_model rcs_agent_model_inst (.clk, .rst_n, .want,
        .addr_line_fifteen_n(a15), .bus_speed_strap(sp),
        .intc_data_line0(d0));
    rcs_strap_sampler rcs_strap_sampler_inst (.clk, .rst_n,
        .addr_line_fifteen_n(a15), .bus_speed_strap(sp), .intc_data_line0(d0),
        .stop_clock_request_n(stp_n), .priority_snoop_req(p_rq),
        .symmetric_snoop_req(s_rq), .interrupt_req(i_rq),
        .stop_grant_active(sg), .fast_wake_active(fw),
        .priority_snoop_ack(pa), .symmetric_snoop_ack(sa),
        .interrupt_latched(il), .intc_enabled(ie), .s_axi_awaddr(aw),
        .s_axi_awvalid(aw_v), .s_axi_awready(aw_a), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_a),
        .s_axi_bresp(br), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
        .s_axi_araddr(ar), .s_axi_arvalid(ar_v), .s_axi_arready(ar_a),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(r_v),
        .s_axi_rready(r_r));
    task automatic chk(input string nm, input logic [33:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stop_test
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
        input logic [1:0] e);
        aw <= a;
        wd <= d;
        aw_v <= 1;
        w_v <= 1;
        b_r <= 1;
        do begin
            @(posedge clk);
            if (aw_a) aw_v <= 0;
            if (w_a) w_v <= 0;
        end while (!b_v);
        b_r <= 0;
        chk("bresp", {32'h0, br}, {32'h0, e});
        @(posedge clk);
    endtask : wr
    // expected value is queued; the monitor below compares it
    task automatic rdq(input logic [3:0] a, input logic [31:0] m, e,
        input logic [1:0] r);
        q.push_back({m, r, e});
        ar <= a;
        ar_v <= 1;
        r_r <= 1;
        do begin
            @(posedge clk);
            if (ar_a) ar_v <= 0;
        end while (!r_v);
        r_r <= 0;
        @(posedge clk);
    endtask : rdq
    always @(posedge clk) begin
        if (r_v && r_r && q.size() > 0) begin
            chk("rdata", {rr, rd & q[0][65:34]}, q[0][33:0]);
            void'(q.pop_front());
        end
    end
    // hang guard, well above the four passes
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_fail++;
            stop_test();
        end
    end
    always @(posedge clk) {p_rq, s_rq, i_rq} <= 3'($urandom);
    initial forever #10 clk = ~clk;
    initial begin
        void'($urandom(32'h7B1E825F));
        cfg = '{4'b0011, 4'b1110, 4'b0000, 4'b1101};
        for (int i = 0; i < 4; i++) begin
            want <= cfg[i];
            rst_n <= 0;
            repeat (16) @(posedge clk);
            rst_n <= 1;
            repeat (3) @(posedge clk);
            spc = cfg[i][2:1] == `RCS_STRAP_100 ? `RCS_SPEED_100 :
                cfg[i][2:1] == `RCS_STRAP_133 ? `RCS_SPEED_133 : `RCS_SPEED_66;
            wr(4'h0, $urandom, `RCS_RESP_SLVERR);
            rdq(4'h0, 32'h000C0020, {12'h0, spc, 12'h0, !cfg[i][3], 5'h0},
                `RCS_RESP_OKAY);
            rdq(4'h8, 32'h00000800, {20'h0, cfg[i][0], 11'h0}, `RCS_RESP_OKAY);
            rdq(4'h2, 32'hFFFFFFFF, 32'h0, `RCS_RESP_SLVERR);
            wr(4'hC, 32'h1, `RCS_RESP_OKAY);
            stp_n <= 0;
            repeat (4) @(posedge clk);
            rdq(4'h4, 32'h3, cfg[i][3] ? 32'h1 : 32'h2, `RCS_RESP_OKAY);
            stp_n <= 1;
            wr(4'h8, 32'h0, `RCS_RESP_OKAY);
            wr(4'h8, 32'h800, `RCS_RESP_OKAY);
            rdq(4'h8, 32'h00000800, 32'h0, `RCS_RESP_OKAY);
            $display("pass %0d done", i);
        end
        stop_test();
    end
endmodule : rcs_strap_sampler_test
`default_nettype wire

// >>> verilog/rcs_params.svh
// offsets, field positions, speed, strap and response codes of the strap sampler
`ifndef RCS_PARAMS_SVH
`define RCS_PARAMS_SVH
`define RCS_OFF_POWER_ON_CONFIGURATION 4'h0
`define RCS_OFF_POWER_STATE 4'h4
`define RCS_OFF_INTC_BASE 4'h8
`define RCS_OFF_CONTROL 4'hC
`define RCS_BIT_FAST_WAKE 5
`define RCS_BIT_SPEED_LO 18
`define RCS_BIT_SPEED_HI 19
`define RCS_BIT_INTC_ENABLE 11
`define RCS_SPEED_66 2'h0
`define RCS_SPEED_100 2'h2
`define RCS_SPEED_133 2'h1
`define RCS_STRAP_66 2'h0
`define RCS_STRAP_100 2'h1
`define RCS_STRAP_133 2'h3
`define RCS_RESP_OKAY 2'h0
`define RCS_RESP_SLVERR 2'h2
`endif

// >>> verilog/rcs_pkg.sv
// types of the strap sampler
package rcs_pkg;
    typedef enum logic [1:0] {
        rcs_running = 2'b00,
        rcs_stop_grant = 2'b01,
        rcs_fast_wake = 2'b10
    } rcs_power_type;
endpackage : rcs_pkg

// >>> verilog/rcs_strap_sampler.sv
// reset configuration strap sampler with axi4-lite register access
// Operation
// - capture straps only at reset release edge
// - address straps sampled at reset release
// - stop request normally enters clock-stop grant
// - fast-wake strap selects fast-wake state instead
// - fast-wake still services priority agent snoops
// - fast-wake blocks symmetric snoops and interrupts
// - bit 5 reports fast-wake enable
// - bus speed shown in bits 19:18
// - speed codes 66=00, 100=10, 133=01
// - data line 0 low clears global enable
// - otherwise global enable set at reset
// - cleared enable disables controller until reset
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "rcs_params.svh"
module rcs_strap_sampler
    import rcs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // straps and power request pins
    input wire logic addr_line_fifteen_n,
    input wire logic [1:0] bus_speed_strap,
    input wire logic intc_data_line0,
    input wire logic stop_clock_request_n,
    // snoop and interrupt sources
    input wire logic priority_snoop_req,
    input wire logic symmetric_snoop_req,
    input wire logic interrupt_req,
    // power state and gated services
    output logic stop_grant_active,
    output logic fast_wake_active,
    output logic priority_snoop_ack,
    output logic symmetric_snoop_ack,
    output logic interrupt_latched,
    output logic intc_enabled,
    // axi4-lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    logic in_reset;
    logic fast_wake_en;
    logic [1:0] speed_code;
    logic [1:0] next_speed_code;
    logic intc_global_en;
    rcs_power_type power_state;
    rcs_power_type next_power_state;
    logic [3:0] aw_addr;
    logic aw_held;
    logic w_held;
    logic [3:0] w_strb;
    logic [31:0] w_data;
    logic write_go;

    // register map seen over the bus:
    //   0x0 power-on configuration, read-only
    //       bit 5 fast-wake strap, bits 19:18 bus speed code
    //   0x4 power state, read-only: 00 run, 01 stop grant, 10 fast wake
    //   0x8 interrupt controller base, bit 11 global enable
    //       a zero clears it; a one never sets it again before reset
    //   0xC control, bit 0 priority snoop service enable
    // writes to the read-only words are refused with an error response
    logic ctl_ack_en;
    logic [31:0] config_word;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    // remembers reset so the release edge can be seen synchronously
    always_ff @(posedge clk) begin
        in_reset <= ~rst_n;
    end

    // speed strap decode; the reserved code falls back to the slow bus
    always_comb begin
        next_speed_code = `RCS_SPEED_66;
        unique case (bus_speed_strap)
            `RCS_STRAP_100: next_speed_code = `RCS_SPEED_100;
            `RCS_STRAP_133: next_speed_code = `RCS_SPEED_133;
            default: next_speed_code = `RCS_SPEED_66;
        endcase
    end

    // straps latched only on the first clock after release
    // pin activity after that edge is ignored until the next reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fast_wake_en <= 1'b0;
        end else if (in_reset) begin
            fast_wake_en <= ~addr_line_fifteen_n;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            speed_code <= `RCS_SPEED_66;
        end else if (in_reset) begin
            speed_code <= next_speed_code;
        end
    end

    // global enable set by reset, may only be cleared until next reset
    // uses the parked write data, the live bus may already have moved on
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            intc_global_en <= 1'b1;
        end else if (in_reset && !intc_data_line0) begin
            intc_global_en <= 1'b0;
        end else if (write_go && aw_addr == `RCS_OFF_INTC_BASE
                     && w_strb[1] && !w_data[`RCS_BIT_INTC_ENABLE]) begin
            intc_global_en <= 1'b0;
        end
    end

    assign intc_enabled = intc_global_en;

    // stop request power state
    always_comb begin
        next_power_state = rcs_running;
        if (!stop_clock_request_n) begin
            next_power_state = fast_wake_en ? rcs_fast_wake
                                            : rcs_stop_grant;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || in_reset) begin
            power_state <= rcs_running;
        end else begin
            power_state <= next_power_state;
        end
    end

    assign stop_grant_active = (power_state == rcs_stop_grant);
    assign fast_wake_active = (power_state == rcs_fast_wake);

    // snoop and interrupt gating
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            priority_snoop_ack <= 1'b0;
            symmetric_snoop_ack <= 1'b0;
            interrupt_latched <= 1'b0;
        end else begin
            priority_snoop_ack <= priority_snoop_req & ctl_ack_en;
            symmetric_snoop_ack <= symmetric_snoop_req
                                   & (power_state != rcs_fast_wake);
            interrupt_latched <= interrupt_req & intc_global_en
                                 & (power_state != rcs_fast_wake);
        end
    end

    // configuration word is read-only
    always_comb begin
        config_word = 32'h0000_0000;
        config_word[`RCS_BIT_FAST_WAKE] = fast_wake_en;
        config_word[`RCS_BIT_SPEED_HI:`RCS_BIT_SPEED_LO] = speed_code;
    end

    // write channels: address and data parked until both arrive
    // ready stays low while a response is pending, so no beat is lost
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;
    assign write_go = aw_held & w_held;

    // write address parking
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            aw_addr <= 4'h0;
        end else if (write_go) begin
            aw_held <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
    end

    // write data parking
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            w_held <= 1'b0;
            w_strb <= 4'h0;
            w_data <= 32'h0000_0000;
        end else if (write_go) begin
            w_held <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_strb <= s_axi_wstrb;
            w_data <= s_axi_wdata;
        end
    end

    // write response follows both beats by one clock
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RCS_RESP_OKAY;
        end else if (write_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr == `RCS_OFF_INTC_BASE
                            || aw_addr == `RCS_OFF_CONTROL)
                           ? `RCS_RESP_OKAY : `RCS_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // control register: priority snoop service enable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl_ack_en <= 1'b1;
        end else if (write_go && aw_addr == `RCS_OFF_CONTROL
                     && w_strb[0]) begin
            ctl_ack_en <= w_data[0];
        end
    end

    // read channel: one read at a time, address taken when idle
    assign s_axi_arready = ~s_axi_rvalid;

    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rresp = `RCS_RESP_OKAY;
        unique case (s_axi_araddr)
            `RCS_OFF_POWER_ON_CONFIGURATION: next_rdata = config_word;
            `RCS_OFF_POWER_STATE: next_rdata = {30'h0, power_state};
            `RCS_OFF_INTC_BASE:
                next_rdata = {20'h0, intc_global_en, 11'h0};
            `RCS_OFF_CONTROL: next_rdata = {31'h0, ctl_ack_en};
            default: next_rresp = `RCS_RESP_SLVERR;
        endcase
    end

    // read valid stands until the master takes it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // read data is frozen while valid stands
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RCS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

endmodule : rcs_strap_sampler
`default_nettype wire
